// ==== rtl/fao_consts.svh ====
`ifndef FAO_CONSTS_SVH
`define FAO_CONSTS_SVH

// Resolution of the converter and size of the comparator ladder.
`define FAO_RES_BITS 9
`define FAO_LADDER_SIZE 512
// Comparator latch offset after the rising strobe edge, in ns.
`define FAO_SAMPLING_OFFSET_NS 10
`define FAO_CLOCK_PERIOD_NS 10
`define FAO_SAMPLING_OFFSET_CYC \
    ((`FAO_SAMPLING_OFFSET_NS + `FAO_CLOCK_PERIOD_NS - 1) / \
    `FAO_CLOCK_PERIOD_NS)
// Strobe periods from sample to capture.
`define FAO_LATENCY_STROBES 2
`define FAO_BUF_DEPTH 2

`endif

// ==== rtl/fao_pkg.sv ====
package fao_pkg;
    typedef logic [8:0] fao_word_type;
    typedef logic [511:0] fao_therm_type;
    typedef enum logic [2:0] {
        FAO_IDLE = 3'b001,
        FAO_LATCH = 3'b010,
        FAO_WAIT = 3'b100
    } fao_state_type;
endpackage

// ==== rtl/fao_buffer.sv ====
`timescale 1ns/10ps
`include "fao_consts.svh"

// Two-entry buffer; holds words while the receiver stalls.
module fao_buffer #(
    parameter int WIDTH = 10
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_ff [2];
    logic [WIDTH-1:0] nxt_mem [2];
    logic rd_ptr_ff, nxt_rd_ptr, wr_ptr_ff, nxt_wr_ptr;
    logic [1:0] count_ff, nxt_count;
    logic push, pop;

    always_comb begin
        in_ready = (count_ff != 2'h2);
        out_valid = (count_ff != 2'h0);
        out_data = mem_ff[rd_ptr_ff];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        nxt_mem = mem_ff;
        if (push) begin
            nxt_mem[wr_ptr_ff] = in_data;
        end
        nxt_wr_ptr = wr_ptr_ff ^ push;
        nxt_rd_ptr = rd_ptr_ff ^ pop;
        nxt_count = count_ff + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
            rd_ptr_ff <= 1'b0;
            wr_ptr_ff <= 1'b0;
            count_ff <= 2'h0;
        end else begin
            mem_ff <= nxt_mem;
            rd_ptr_ff <= nxt_rd_ptr;
            wr_ptr_ff <= nxt_wr_ptr;
            count_ff <= nxt_count;
        end
    end
endmodule

// ==== rtl/fao_pipeline.sv ====
`timescale 1ns/10ps
`include "fao_consts.svh"

module fao_pipeline #(
    parameter int RES_BITS = `FAO_RES_BITS,
    parameter int LADDER = `FAO_LADDER_SIZE
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Sample strobe, differential.
    input wire logic sample_strobe,
    input wire logic sample_strobe_n,
    // Comparator ladder; bit LADDER-1 is the over-range comparator.
    input wire fao_pkg::fao_therm_type comparators,
    // Result outputs, true and complement, bit 8 is result_msb.
    output fao_pkg::fao_word_type result_true,
    output fao_pkg::fao_word_type result_comp,
    output logic over_range_flag,
    output logic over_range_flag_n,
    output logic result_valid,
    // Capture handshake.
    input wire logic capture_ready
);
    import fao_pkg::*;

    // The sampling offset rounded up to whole clock cycles.
    localparam int OFFSET_CYC = `FAO_SAMPLING_OFFSET_CYC;
    // Index of the over-range comparator at the top of the ladder.
    localparam int TOP = LADDER - 1;

    // Index plus one of the highest lit comparator below the top; for a clean
    // thermometer code this equals the count of lit comparators below the top.
    function automatic fao_word_type therm_encode(input fao_therm_type t);
        fao_word_type code;
        code = '0;
        for (int i = 1; i < LADDER; i++) begin
            if (t[i - 1]) begin
                code = i[RES_BITS-1:0];
            end
        end
        return code;
    endfunction

    // The over-range comparator is never part of the encoded count.
    function automatic logic therm_over(input fao_therm_type t);
        return t[TOP];
    endfunction

    // Strobe edge detection.
    logic strobe_q_ff, nxt_strobe_q;
    logic strobe_ok;
    logic rise;
    // Latch sequencer.
    fao_state_type state_ff, nxt_state;
    logic [1:0] offs_ff, nxt_offs;
    fao_therm_type latch_ff, nxt_latch;
    logic latched_ff, nxt_latched;
    // Encode stage, one word waiting for the next strobe.
    fao_word_type enc_ff, nxt_enc;
    logic enc_ovr_ff, nxt_enc_ovr;
    logic enc_full_ff, nxt_enc_full;
    logic take;
    // Two-entry buffer towards the capture side.
    logic buf_in_ready;
    logic buf_out_valid;
    logic [RES_BITS:0] buf_out_data;
    // Output stage.
    fao_word_type nxt_true;
    fao_word_type nxt_comp;
    logic nxt_ovr;
    logic nxt_ovr_n;
    logic nxt_valid;

    // A sample starts only on a clean differential rise; a pair that is
    // equal on both legs is treated as no strobe.
    always_comb begin
        strobe_ok = sample_strobe && !sample_strobe_n;
        rise = strobe_ok && !strobe_q_ff;
        nxt_strobe_q = strobe_ok;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            strobe_q_ff <= 1'b0;
        end else begin
            strobe_q_ff <= nxt_strobe_q;
        end
    end

    // The comparators are latched the sampling offset after the rise.
    // Rises that arrive while a latch is pending are ignored, so the
    // capture side must keep its strobes at least two cycles apart.
    // With an offset of one cycle the wait state is skipped entirely.
    always_comb begin
        nxt_state = state_ff;
        nxt_offs = offs_ff;
        nxt_latch = latch_ff;
        nxt_latched = 1'b0;
        case (state_ff)
            FAO_IDLE: begin
                if (rise) begin
                    nxt_offs = 2'(OFFSET_CYC - 1);
                    nxt_state = (OFFSET_CYC <= 1) ? FAO_LATCH : FAO_WAIT;
                end
            end
            FAO_WAIT: begin
                nxt_offs = offs_ff - 2'h1;
                if (offs_ff <= 2'h1) begin
                    nxt_state = FAO_LATCH;
                end
            end
            FAO_LATCH: begin
                nxt_latch = comparators;
                nxt_latched = 1'b1;
                nxt_state = FAO_IDLE;
            end
            default: begin
                nxt_state = FAO_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_ff <= FAO_IDLE;
            offs_ff <= 2'h0;
            latch_ff <= '0;
            latched_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            offs_ff <= nxt_offs;
            latch_ff <= nxt_latch;
            latched_ff <= nxt_latched;
        end
    end

    // Encode the latched sample; it waits here for the next strobe. A new
    // sample that finds the buffer full overwrites the waiting word, so a
    // long stall drops samples here and never inside the buffer.
    always_comb begin
        nxt_enc = enc_ff;
        nxt_enc_ovr = enc_ovr_ff;
        nxt_enc_full = enc_full_ff;
        // The next strobe edge moves the encoded word to the buffer.
        take = rise && enc_full_ff && buf_in_ready;
        if (take) begin
            nxt_enc_full = 1'b0;
        end
        // A fresh sample wins over a transfer in the same cycle.
        if (latched_ff) begin
            nxt_enc = therm_encode(latch_ff);
            nxt_enc_ovr = therm_over(latch_ff);
            nxt_enc_full = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            enc_ff <= '0;
            enc_ovr_ff <= 1'b0;
            enc_full_ff <= 1'b0;
        end else begin
            enc_ff <= nxt_enc;
            enc_ovr_ff <= nxt_enc_ovr;
            enc_full_ff <= nxt_enc_full;
        end
    end

    // The flag rides in the top bit of each buffer entry so that it can
    // never part from the word it describes.
    fao_buffer #(
        .WIDTH(RES_BITS + 1)
    ) u_buffer (
        .clock(clock),
        .reset(reset),
        .in_valid(take),
        .in_ready(buf_in_ready),
        .in_data({enc_ovr_ff, enc_ff}),
        .out_valid(buf_out_valid),
        .out_ready(capture_ready),
        .out_data(buf_out_data)
    );

    // Outputs keep the old word until the buffer presents a new one; both
    // legs of every pair come from registers of the same edge, so the
    // pair never shows two equal legs. A stalled capture side simply
    // leaves the last word standing.
    always_comb begin
        nxt_true = result_true;
        nxt_ovr = over_range_flag;
        nxt_valid = buf_out_valid;
        if (buf_out_valid && capture_ready) begin
            nxt_true = buf_out_data[RES_BITS-1:0];
            nxt_ovr = buf_out_data[RES_BITS];
        end
        nxt_comp = ~nxt_true;
        nxt_ovr_n = ~nxt_ovr;
    end

    // Reset shows code zero with a dark flag on both legs of each pair.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            result_true <= '0;
            result_comp <= '1;
            over_range_flag <= 1'b0;
            over_range_flag_n <= 1'b1;
            result_valid <= 1'b0;
        end else begin
            result_true <= nxt_true;
            result_comp <= nxt_comp;
            over_range_flag <= nxt_ovr;
            over_range_flag_n <= nxt_ovr_n;
            result_valid <= nxt_valid;
        end
    end
endmodule

// ==== dv/fao_pipeline_monitor.sv ====
`timescale 1ns/10ps
module fao_monitor
    import fao_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic capture_ready,
    input wire fao_word_type result_true,
    input wire fao_word_type result_comp,
    input wire logic over_range_flag,
    input wire logic over_range_flag_n,
    input wire logic result_valid
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_took;
        $past(capture_ready);
    endsequence
    AST_COMP_PAIR:
        assert property (result_comp == ~result_true) else $error("comp");
    AST_FLAG_PAIR:
        assert property (over_range_flag_n == !over_range_flag)
            else $error("fn");
    AST_WORD_HOLD:
        assert property ($changed(result_true) |-> s_took) else $error("hold");
    AST_FLAG_HOLD:
        assert property ($changed(over_range_flag) |-> s_took)
            else $error("fl");
    AST_RST_WORD:
        assert property ($fell(reset) |-> result_true == 9'h000)
            else $error("rw");
    AST_RST_FLAG:
        assert property ($fell(reset) |-> !over_range_flag) else $error("rf");
    AST_RST_VALID:
        assert property ($fell(reset) |-> !result_valid) else $error("rv");
    AST_CHG_VALID:
        assert property ($changed(result_true) |->
            result_valid || $past(result_valid)) else $error("cv");
endmodule

// ==== dv/fao_capture.sv ====
`timescale 1ns/10ps
module fao_capture (
    input wire logic clock,
    input wire logic stall,
    input wire fao_pkg::fao_word_type result_true,
    output logic capture_ready,
    output fao_pkg::fao_word_type offset_word
);
    import fao_pkg::*;
    always_ff @(posedge clock) begin
        capture_ready <= !stall;
    end
    assign offset_word = result_true ^ 9'h100;
endmodule

// ==== dv/tb_flash_adc_output_pipeline.sv ====
`timescale 1ns/10ps
module tb_flash_adc_output_pipeline;
    import fao_pkg::*;
    logic clock = 0, reset = 1, strobe = 0, stall = 0;
    fao_therm_type comparators = '0;
    fao_word_type result_true, result_comp, offset;
    logic flag, flag_n, valid, capture_ready;
    int err_count = 0, compares = 0;
    always #5 clock = ~clock;
    fao_pipeline u_dut (.clock, .reset, .sample_strobe(strobe),
        .sample_strobe_n(~strobe), .comparators, .result_true,
        .result_comp, .over_range_flag(flag), .over_range_flag_n(flag_n),
        .result_valid(valid), .capture_ready);
    fao_capture u_cap (.clock, .stall, .result_true, .capture_ready,
        .offset_word(offset));
    function automatic logic [9:0] want(input int n);
        return {n == 512, n > 511 ? 9'h1ff : 9'(n)};
    endfunction
    task automatic check(input logic [9:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // One strobe rise with n comparators lit, held high one cycle, then two cycles low.
    task automatic pulse(input int n);
        @(posedge clock);
        strobe <= 1'b1;
        comparators <= (512'h1 << n) - 512'h1;
        @(posedge clock);
        strobe <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic next_word(input int n);
        logic [9:0] old;
        old = {flag, result_true};
        for (int i = 0; i < 20 && {flag, result_true} === old; i++) begin
            @(posedge clock);
        end
        check({flag, result_true}, want(n));
    endtask
    task automatic t_codes();
        int n[6] = '{0, 1, 256, 511, 512, 5};
        fao_word_type off_exp[6] = '{9'h100, 9'h101, 9'h000, 9'h0ff,
            9'h0ff, 9'h105};
        for (int i = 0; i < 6; i++) begin
            pulse(n[i]);
            if (i > 0) begin
                check({flag, result_true}, want(n[i-1]));
                check({flag_n, result_comp}, ~want(n[i-1]));
                check({1'b0, offset}, {1'b0, off_exp[i-1]});
            end
        end
    endtask
    // Stalled capture must not change the shown word; the two buffered words then come out in order.
    task automatic t_stall();
        stall <= 1'b1;
        @(posedge clock);
        pulse(3);
        pulse(4);
        pulse(6);
        pulse(7);
        check({flag, result_true}, want(512));
        stall <= 1'b0;
        next_word(5);
        next_word(3);
    endtask
    initial begin
        #5000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        t_codes();
        t_stall();
        give_verdict();
    end
endmodule
bind fao_pipeline fao_monitor u_mon (.clock, .reset, .capture_ready,
    .result_true, .result_comp, .over_range_flag, .over_range_flag_n,
    .result_valid);
